// *** dv/pio_far_end.sv ***
/*
  Far-side parallel device model: sink that acknowledges offered words,
  source that offers words when the bench calls offer.
  Assumes the bench resolves the wired-low request/acknowledge levels.
*/
`timescale 1ns/1ps
module pio_far_end (
  input wire logic pclk,
  input wire logic req_w,
  input wire logic ack_w,
  input wire logic [31:0] data_w,
  output logic req_oe,
  output logic ack_oe,
  output logic [31:0] drv_data,
  output logic drv_oe
);
  logic [31:0] got[$];
  int slow = 0;
  task automatic stuck;
    tb.failures++;
    tb.conclude();
  endtask
  initial begin
    req_oe = 1'b0;
    ack_oe = 1'b0;
    drv_oe = 1'b0;
    drv_data = 32'h0;
  end
  // ----------------------------------------
  // sink: take word, hold acknowledge low
  // ----------------------------------------
  always @(posedge pclk) begin : sink
    int k;
    if (!req_w && !req_oe && !ack_oe) begin
      got.push_back(data_w);
      repeat (slow) @(posedge pclk);
      ack_oe <= 1'b1;
      k = 0;
      while (!req_w && k < 3000) begin @(posedge pclk); k++; end
      if (k >= 3000) stuck();
      ack_oe <= 1'b0;
    end
  end
  // ----------------------------------------
  // source: data first, then request
  // ----------------------------------------
  task automatic offer(input logic [31:0] d);
    int k;
    drv_data <= d;
    drv_oe <= 1'b1;
    repeat (3) @(posedge pclk);
    req_oe <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (ack_w && k < 3000);
    if (k >= 3000) stuck();
    repeat (slow) @(posedge pclk);
    req_oe <= 1'b0;
    drv_oe <= 1'b0;
    k = 0;
    do begin @(posedge pclk); k++; end while (!ack_w && k < 3000);
    if (k >= 3000) stuck();
  endtask
endmodule // pio_far_end

// *** dv/tb.sv ***
/*
  Bench for the parallel I/O handshake port: APB and FIFO-side tasks,
  far-side model on the P2 lines, directed sequences.
  Assumes the design header offsets and a 40 ns clock.
*/
`timescale 1ns/1ps
`include "pio_port_consts.svh"
module tb;
  import pio_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, fifo_rd_data, data_w, far_data, rdata, fdata;
  logic pready, pslverr, latch_move_done_n, fifo_flow_dir, req_w, ack_w, far_req_oe, far_ack_oe, far_oe, rerr;
  logic latch_move_request_n = 1'b1;
  logic latch_move_request_alt_n = 1'b1;
  logic [31:0] fifo_wr_data = 32'h0;
  logic [31:0] noise = 32'h0;
  logic [7:0] status_in = 8'h00;
  logic [7:0] control_out;
  p2_drive_t p2_drive;
  logic [2:0] burst_cycle_count;
  logic transfer_go_n, block_mode_enable, io_size_select_hi, io_size_select_lo, vme_wide_word_n, half_word_toggle;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] words[2] = '{32'h8421_c3a5, 32'h1234_5678};
  int n, w;
  logic [31:0] mask;

  always #20 pclk = ~pclk;
  always @(posedge pclk) noise <= noise + 32'h9e37_79b9;
  assign req_w = !(p2_drive.req_oe || far_req_oe);
  assign ack_w = !(p2_drive.ack_oe || far_ack_oe);
  assign data_w = p2_drive.data_oe ? p2_drive.data_out : (far_oe ? far_data : noise);

  parallel_io_handshake_port i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .latch_move_request_n(latch_move_request_n), .latch_move_request_alt_n(latch_move_request_alt_n),
    .fifo_wr_data(fifo_wr_data), .fifo_rd_data(fifo_rd_data), .latch_move_done_n(latch_move_done_n),
    .fifo_flow_dir(fifo_flow_dir), .p2_data_in(data_w), .req_in(req_w), .ack_in(ack_w),
    .status_in(status_in), .p2_drive(p2_drive), .control_out(control_out), .transfer_go_n(transfer_go_n),
    .burst_cycle_count(burst_cycle_count), .block_mode_enable(block_mode_enable),
    .io_size_select_hi(io_size_select_hi), .io_size_select_lo(io_size_select_lo),
    .vme_wide_word_n(vme_wide_word_n), .half_word_toggle(half_word_toggle)
  );
  pio_far_end i_far (
    .pclk(pclk), .req_w(req_w), .ack_w(ack_w), .data_w(data_w),
    .req_oe(far_req_oe), .ack_oe(far_ack_oe), .drv_data(far_data), .drv_oe(far_oe)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin failures++; conclude(); end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic fifo_move(input logic [31:0] d, input logic alt);
    int k;
    fifo_wr_data <= d;
    {latch_move_request_alt_n, latch_move_request_n} <= alt ? 2'b01 : 2'b10;
    k = 0;
    do begin @(posedge pclk); k++; end while (latch_move_done_n !== 1'b0 && k < 3000);
    if (k >= 3000) begin failures++; conclude(); end
    fdata = fifo_rd_data;
    {latch_move_request_alt_n, latch_move_request_n} <= 2'b11;
    @(posedge pclk);
  endtask
  task automatic wait_done(input logic [2:0] exp);
    int k;
    k = 0;
    do begin apb(1'b0, `OFF_STATUS, 32'h0); k++; end while (rdata[2:0] !== exp && k < 300);
    if (k >= 300) begin failures++; conclude(); end
    chk(64'({fifo_flow_dir, p2_drive.external_flow_direction, p2_drive.data_oe}), 64'h0);
    chk(64'({p2_drive.req_oe, p2_drive.ack_oe}), 64'h0);
    apb(1'b1, `OFF_STATUS, 32'h6);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(64'(rdata[2:0]), 64'h0);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(64'(p2_drive), 64'h0);
    chk(64'({latch_move_done_n, transfer_go_n, pready}), 64'h7);
    $display("test reset done");
    status_in <= 8'h3c;
    apb(1'b1, `OFF_CTRL_BYTE, 32'h0000_a500);
    chk(64'(control_out), 64'ha5);
    apb(1'b1, `OFF_DSP_MEM, 32'h0000_5a00);
    chk(64'(control_out), 64'h5a);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(64'(rdata[15:8]), 64'h3c);
    apb(1'b0, `OFF_DSP_MEM, 32'h0);
    chk(64'(rdata[15:8]), 64'h3c);
    apb(1'b0, 12'h020, 32'h0);
    chk(64'({rerr, rdata}), 64'h1_0000_0000);
    $display("test control status done");
    apb(1'b1, `OFF_PIO, 32'h0000_beef);
    chk(64'(half_word_toggle), 64'h1);
    apb(1'b1, `OFF_PIO, 32'h0000_cafe);
    chk(64'({p2_drive.data_oe, p2_drive.data_out}), 64'h1_beef_cafe);
    apb(1'b0, `OFF_PIO, 32'h0);
    chk(64'({p2_drive.data_oe, rdata[15:0]}), 64'h0_beef);
    $display("test programmed io done");
    apb(1'b1, `OFF_SRC_ATTR, 32'h3);
    apb(1'b1, `OFF_DST_ATTR, 32'h1);
    for (int k = 0; k < 3; k++) begin
      n = 4 >> k;
      w = 8 << k;
      mask = (k == 2) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
      i_far.got.delete();
      i_far.slow = (k == 1) ? 4 : 0;
      apb(1'b1, `OFF_COUNT, 32'h2);
      apb(1'b1, `OFF_CTRL, {24'h0, k == 0, 3'h1, 1'b0, 2'(k + 1), 1'b1});
      chk(64'({fifo_flow_dir, p2_drive.external_flow_direction}), 64'h3);
      chk(64'({transfer_go_n, block_mode_enable, burst_cycle_count}), 64'({k == 0, 3'h1}));
      fifo_move(words[0], 1'b0);
      fifo_move(words[1], k == 1);
      wait_done(3'b010);
      chk(64'(i_far.got.size()), 64'(2 * n));
      foreach (i_far.got[b]) chk(64'(i_far.got[b] & mask), 64'((words[b / n] >> ((b % n) * w)) & mask));
    end
    $display("test outbound done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `OFF_COUNT, 32'(k + 1));
      apb(1'b1, `OFF_CTRL, {28'h0, k[0], 3'b111});
      wait_done(3'b100);
    end
    $display("test refused done");
    i_far.slow = 2;
    apb(1'b1, `OFF_SRC_ATTR, 32'h1);
    apb(1'b1, `OFF_DST_ATTR, 32'h3);
    apb(1'b1, `OFF_COUNT, 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h0000_000b);
    chk(64'({fifo_flow_dir, p2_drive.external_flow_direction}), 64'h0);
    chk(64'({vme_wide_word_n, io_size_select_hi, io_size_select_lo}), 64'h5);
    fork
      begin
        i_far.offer(32'hffff_ff5a);
        i_far.offer(32'h0000_00c3);
      end
    join_none
    fifo_move(32'h0, 1'b1);
    chk(64'(fdata[15:0]), 64'hc35a);
    wait_done(3'b010);
    $display("test inbound done");
    conclude();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    conclude();
  end
endmodule // tb

// *** hdl/parallel_io_handshake_port.sv ***
/*
  Parallel I/O handshake port: APB registers, FIFO-side word mover,
  size multiplexing, open-drain request/acknowledge on the P2 lines,
  programmed I/O and control/status bytes.
  Assumes the FIFO logic runs on pclk and the far party is asynchronous.
*/
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pio_port_consts.svh"

// Notes on behaviour
// - data source drives the request strobe
// - data sink drives the acknowledge strobe
// - strobes released until transfer starts
// - external direction low inbound, high outbound
// - FIFO direction 1 outbound, 0 inbound
// - I/O words 8/16/32, VME words 16/32
// - hardware size multiplexing between both widths
// - up to ten million transfers per second
// - eight control outputs, eight status inputs
// - control byte written by VME or DSP
// - status byte read by VME or DSP
// - sizes from two selects and wide flag
// - port access alternates upper/lower halves
// - FIFO request answered by latch acknowledge
// - moves only while transfer-go asserted
// - burst count and block enable shape bursts
// - programmed I/O reaches data line latches
// - direction follows from two attribute words
// - low two attribute bits select endpoint
// - codes: DRAM, I/O type1, type2, VME
// - idle: direction low, buffers off except after a PIO write (until a PIO read or start)
// - strobes open-drain, active low
// - single 32-bit word transfer refused
module parallel_io_handshake_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  input wire logic latch_move_request_n,
  input wire logic latch_move_request_alt_n,
  input wire logic [31:0] fifo_wr_data,
  output logic [31:0] fifo_rd_data,
  output wire logic latch_move_done_n,
  output wire logic fifo_flow_dir,
  input wire logic [31:0] p2_data_in,
  input wire logic req_in,
  input wire logic ack_in,
  input wire logic [7:0] status_in,
  output wire pio_pkg::p2_drive_t p2_drive,
  output wire logic [7:0] control_out,
  output wire logic transfer_go_n,
  output wire logic [2:0] burst_cycle_count,
  output wire logic block_mode_enable,
  output wire logic io_size_select_hi,
  output wire logic io_size_select_lo,
  output wire logic vme_wide_word_n,
  output wire logic half_word_toggle
);
  import pio_pkg::*;

  // ----------------------------------------
  // lane helpers
  // ----------------------------------------
  function automatic logic [1:0] last_beat(input logic [1:0] sz, input logic wide_n);
    logic [1:0] r;
    r = 2'd0;
    if (sz == `SIZE_8) r = wide_n ? 2'd1 : 2'd3;
    else if (sz == `SIZE_16) r = wide_n ? 2'd0 : 2'd1;
    return r;
  endfunction

  function automatic logic [31:0] lane_get(input logic [31:0] w, input logic [1:0] sz,
                                           input logic [1:0] idx);
    logic [31:0] r;
    r = w;
    if (sz == `SIZE_8) r = {24'h000000, w[{idx, 3'b000} +: 8]};
    else if (sz == `SIZE_16) r = {16'h0000, w[{idx[0], 4'h0} +: 16]};
    return r;
  endfunction

  function automatic logic [31:0] lane_put(input logic [31:0] w, input logic [31:0] d,
                                           input logic [1:0] sz, input logic [1:0] idx);
    logic [31:0] r;
    r = w;
    if (sz == `SIZE_8) r[{idx, 3'b000} +: 8] = d[7:0];
    else if (sz == `SIZE_16) r[{idx[0], 4'h0} +: 16] = d[15:0];
    else r = d;
    return r;
  endfunction

  // ----------------------------------------
  // registers and synchronisers
  // ----------------------------------------
  xfer_cfg_t cfg;
  state_t state;
  state_t next_state;
  logic [1:0] src_attr;
  logic [1:0] dst_attr;
  logic [15:0] count;
  logic [15:0] words_left;
  logic [7:0] ctrl_byte;
  logic [31:0] wbuf;
  logic [31:0] p2_data;
  logic [1:0] bidx;
  logic [2:0] burst_cnt;
  logic xdir;
  logic done;
  logic err;
  logic toggle;
  logic pio_drive;
  logic [41:0] sync1;
  logic [41:0] sync2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= `SYNC_RST;
      sync2 <= `SYNC_RST;
    end else begin
      sync1 <= {req_in, ack_in, status_in, p2_data_in};
      sync2 <= sync1;
    end
  end

  wire req_s = sync2[41];
  wire ack_s = sync2[40];
  wire [7:0] status_s = sync2[39:32];
  wire [31:0] p2_in_s = sync2[31:0];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_access = access & pwrite;
  wire rd_access = access & ~pwrite;
  wire hit_ctrl = paddr == `OFF_CTRL;
  wire hit_src = paddr == `OFF_SRC_ATTR;
  wire hit_dst = paddr == `OFF_DST_ATTR;
  wire hit_count = paddr == `OFF_COUNT;
  wire hit_status = paddr == `OFF_STATUS;
  wire hit_cbyte = paddr == `OFF_CTRL_BYTE;
  wire hit_pio = paddr == `OFF_PIO;
  wire hit_dsp = paddr == `OFF_DSP_MEM;
  wire mapped = hit_ctrl | hit_src | hit_dst | hit_count | hit_status | hit_cbyte | hit_pio | hit_dsp;
  wire busy = state != ST_IDLE;
  wire ctrl_wr = wr_access & hit_ctrl;
  wire pio_wr = wr_access & hit_pio & ~busy;
  wire pio_rd = rd_access & hit_pio;
  wire [31:0] status_word = {16'h0000, status_s, 4'h0, xdir, err, done, busy};
  wire [31:0] pio_word = {16'h0000, toggle ? p2_in_s[15:0] : p2_in_s[31:16]};
  wire [31:0] rdata =
    hit_ctrl ? {24'h000000, cfg} :
    hit_src ? {30'h00000000, src_attr} :
    hit_dst ? {30'h00000000, dst_attr} :
    hit_count ? {16'h0000, count} :
    hit_status ? status_word :
    hit_cbyte ? {16'h0000, ctrl_byte, 8'h00} :
    hit_pio ? pio_word :
    hit_dsp ? {16'h0000, status_s, 8'h00} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (setup) prdata <= rdata;
  end

  // ----------------------------------------
  // start decision
  // ----------------------------------------
  wire [1:0] size = {cfg.io_size_select_hi, cfg.io_size_select_lo};
  wire [1:0] wr_size = pwdata[2:1];
  wire wr_wide_n = pwdata[3];
  wire out_dir = (src_attr == `ATTR_VME) && (dst_attr == `ATTR_IO1);
  wire in_dir = (src_attr == `ATTR_IO1) && (dst_attr == `ATTR_VME);
  wire size_ok = (wr_size != `SIZE_NONE) && !((wr_size == `SIZE_32) && wr_wide_n);
  wire single32 = (wr_size == `SIZE_32) && (count == 16'h0001);
  wire start_try = ctrl_wr & pwdata[0] & ~busy;
  wire start_ok = (out_dir | in_dir) & size_ok & ~single32 & (count != `COUNT_RST);
  wire start = start_try & start_ok;

  // ----------------------------------------
  // transfer events
  // ----------------------------------------
  wire go = cfg.go;
  wire fifo_req = ~latch_move_request_n | ~latch_move_request_alt_n;
  wire load_take = (state == ST_LOAD) & go & fifo_req;
  wire deliver_take = (state == ST_DELIVER) & go & fifo_req;
  wire offer_acked = (state == ST_OFFER) & go & ~ack_s;
  wire release_seen = (state == ST_RELEASE) & ack_s;
  wire sink_take = (state == ST_SINK_WAIT) & go & ~req_s;
  wire sink_rel = (state == ST_SINK_ACK) & req_s;
  wire beat_end = release_seen | sink_rel;
  wire [1:0] last_idx = last_beat(size, cfg.vme_wide_word_n);
  wire word_last = bidx == last_idx;
  wire final_word = words_left == 16'h0001;
  wire burst_gap = cfg.block_mode_enable & (burst_cnt == cfg.burst_cycle_count);
  wire word_done = (release_seen & word_last) | deliver_take;
  wire xfer_end = word_done & final_word;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start) next_state = out_dir ? ST_LOAD : ST_SINK_WAIT;
      ST_LOAD: if (load_take) next_state = ST_OFFER;
      ST_OFFER: if (offer_acked) next_state = ST_RELEASE;
      ST_RELEASE: begin
        if (ack_s) begin
          if (word_last && final_word) next_state = ST_IDLE;
          else if (burst_gap) next_state = ST_GAP;
          else next_state = word_last ? ST_LOAD : ST_OFFER;
        end
      end
      ST_SINK_WAIT: if (sink_take) next_state = ST_SINK_ACK;
      ST_SINK_ACK: begin
        if (req_s) begin
          if (word_last) next_state = ST_DELIVER;
          else next_state = burst_gap ? ST_GAP : ST_SINK_WAIT;
        end
      end
      ST_DELIVER: if (deliver_take) next_state = final_word ? ST_IDLE : ST_SINK_WAIT;
      ST_GAP: next_state = !xdir ? ST_SINK_WAIT : (bidx == 2'd0 ? ST_LOAD : ST_OFFER);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= ST_IDLE;
    else state <= next_state;
  end

  // ----------------------------------------
  // word datapath
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bidx <= 2'd0;
      burst_cnt <= 3'd0;
      words_left <= `COUNT_RST;
      xdir <= 1'b0;
    end else begin
      if (start) begin
        bidx <= 2'd0;
        burst_cnt <= 3'd0;
        words_left <= count;
        xdir <= out_dir;
      end else begin
        if (beat_end) bidx <= word_last ? 2'd0 : bidx + 2'd1;
        if (beat_end) burst_cnt <= burst_gap ? 3'd0 : burst_cnt + 3'd1;
        if (word_done) words_left <= words_left - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wbuf <= 32'h00000000;
      fifo_rd_data <= 32'h00000000;
    end else begin
      if (load_take) wbuf <= fifo_wr_data;
      else if (sink_take) wbuf <= lane_put(wbuf, p2_in_s, size, bidx);
      if (sink_take && word_last) fifo_rd_data <= lane_put(wbuf, p2_in_s, size, bidx);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) p2_data <= 32'h00000000;
    else if (load_take) p2_data <= lane_get(fifo_wr_data, size, 2'd0);
    else if (release_seen && !word_last) p2_data <= lane_get(wbuf, size, bidx + 2'd1);
    else if (pio_wr && !toggle) p2_data[31:16] <= pwdata[15:0];
    else if (pio_wr) p2_data[15:0] <= pwdata[15:0];
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `CTRL_RST;
      src_attr <= `ATTR_RST;
      dst_attr <= `ATTR_RST;
      count <= `COUNT_RST;
      ctrl_byte <= `CTRL_BYTE_RST;
    end else begin
      if (ctrl_wr) cfg <= pwdata[`CTRL_W-1:0];
      if (wr_access && hit_src) src_attr <= pwdata[1:0];
      if (wr_access && hit_dst) dst_attr <= pwdata[1:0];
      if (wr_access && hit_count) count <= pwdata[15:0];
      if (wr_access && (hit_cbyte || hit_dsp)) ctrl_byte <= pwdata[`BYTE_LSB +: 8];
    end
  end

  wire clr_done = wr_access & hit_status & pwdata[`STAT_DONE];
  wire clr_err = wr_access & hit_status & pwdata[`STAT_ERR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      err <= 1'b0;
      toggle <= 1'b0;
      pio_drive <= 1'b0;
    end else begin
      done <= (done & ~clr_done) | xfer_end;
      err <= (err & ~clr_err) | (start_try & ~start_ok);
      if (ctrl_wr) toggle <= 1'b0;
      else if (pio_wr || pio_rd) toggle <= ~toggle;
      if (start || pio_rd) pio_drive <= 1'b0;
      else if (pio_wr) pio_drive <= 1'b1;
    end
  end

  // ----------------------------------------
  // pins and FIFO-side outputs
  // ----------------------------------------
  assign p2_drive.data_out = p2_data;
  assign p2_drive.data_oe = busy ? xdir : pio_drive;
  assign p2_drive.req_out = 1'b0;
  assign p2_drive.req_oe = xdir & (state == ST_OFFER);
  assign p2_drive.ack_out = 1'b0;
  assign p2_drive.ack_oe = ~xdir & (state == ST_SINK_ACK);
  assign p2_drive.external_flow_direction = busy & xdir;
  assign fifo_flow_dir = busy & xdir;
  assign latch_move_done_n = ~(load_take | deliver_take);
  assign control_out = ctrl_byte;
  assign transfer_go_n = ~cfg.go;
  assign burst_cycle_count = cfg.burst_cycle_count;
  assign block_mode_enable = cfg.block_mode_enable;
  assign io_size_select_hi = cfg.io_size_select_hi;
  assign io_size_select_lo = cfg.io_size_select_lo;
  assign vme_wide_word_n = cfg.vme_wide_word_n;
  assign half_word_toggle = toggle;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_strobes_off: assert property (!busy |-> !p2_drive.req_oe && !p2_drive.ack_oe)
    else $error("strobe driven while idle");
  a_idle_dir_low: assert property (!busy && !pio_drive |-> !p2_drive.external_flow_direction && !p2_drive.data_oe)
    else $error("idle port drives direction or data");
  a_req_by_source: assert property (p2_drive.req_oe |-> p2_drive.external_flow_direction && fifo_flow_dir)
    else $error("request driven by sink");
  a_ack_by_sink: assert property (p2_drive.ack_oe |-> busy && !p2_drive.external_flow_direction)
    else $error("acknowledge driven by source");
  a_offer_holds: assert property (p2_drive.req_oe && ack_s |=> p2_drive.req_oe && $stable(p2_drive.data_out))
    else $error("offer dropped before acknowledge");
  a_ack_releases: assert property (state == ST_OFFER && go && !ack_s |=> !p2_drive.req_oe)
    else $error("request not released after acknowledge");
  a_no_go_no_move: assert property (!cfg.go |-> latch_move_done_n)
    else $error("word moved without transfer-go");
  a_dsp_ctrl_byte: assert property (wr_access && hit_dsp |=> control_out == $past(pwdata[15:8]))
    else $error("control byte not updated by dsp write");
  a_single_refused: assert property (start_try && single32 |=> err && !busy)
    else $error("single 32-bit word started");
  a_toggle_flip: assert property (pio_rd |=> half_word_toggle != $past(half_word_toggle))
    else $error("half toggle did not alternate");
  a_start_dir: assert property (start && out_dir |=> fifo_flow_dir ##1 fifo_flow_dir)
    else $error("outbound transfer without direction high");

  c_out_word: cover property (state == ST_RELEASE && ack_s && word_last);
  c_in_word: cover property (deliver_take);
  c_burst_gap: cover property (state == ST_GAP);
  c_pio_pair: cover property (pio_wr ##[1:20] pio_rd);
endmodule // parallel_io_handshake_port

// *** hdl/pio_pkg.sv ***
/*
  Types for the parallel I/O handshake port.
  Assumes nothing beyond the constants header.
*/
package pio_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_OFFER = 3'b010,
    ST_RELEASE = 3'b011,
    ST_SINK_WAIT = 3'b100,
    ST_SINK_ACK = 3'b101,
    ST_DELIVER = 3'b110,
    ST_GAP = 3'b111
  } state_t;

  typedef struct packed {
    logic block_mode_enable;
    logic [2:0] burst_cycle_count;
    logic vme_wide_word_n;
    logic io_size_select_hi;
    logic io_size_select_lo;
    logic go;
  } xfer_cfg_t;

  typedef struct packed {
    logic [31:0] data_out;
    logic data_oe;
    logic req_out;
    logic req_oe;
    logic ack_out;
    logic ack_oe;
    logic external_flow_direction;
  } p2_drive_t;

endpackage

// *** hdl/pio_port_consts.svh ***
/*
  Constants for the parallel I/O handshake port: APB offsets, field
  positions, attribute and size codes, reset values.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef PIO_PORT_CONSTS_SVH
`define PIO_PORT_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_SRC_ATTR 12'h004
`define OFF_DST_ATTR 12'h008
`define OFF_COUNT 12'h00c
`define OFF_STATUS 12'h010
`define OFF_CTRL_BYTE 12'h014
`define OFF_PIO 12'h018
`define OFF_DSP_MEM 12'hc00

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_W 8
`define BYTE_LSB 8
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ERR 2
`define STAT_DIR 3

// ----------------------------------------
// codes
// ----------------------------------------
`define ATTR_DRAM 2'b00
`define ATTR_IO1 2'b01
`define ATTR_IO2 2'b10
`define ATTR_VME 2'b11
`define SIZE_NONE 2'b00
`define SIZE_8 2'b01
`define SIZE_16 2'b10
`define SIZE_32 2'b11

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RST 8'h00
`define CTRL_BYTE_RST 8'h00
`define ATTR_RST 2'b00
`define COUNT_RST 16'h0000
`define SYNC_RST 42'h3_0000_0000_00

`endif
